// *** hw/empc_top.sv ***
// Purpose: strap-selected pin direction, power-down pin states, reset stretch
// Assumes: straps and reset pin are asynchronous and pass two flip-flops
// Notes: all outputs registered; enables high while the device drives
`timescale 1ns/100ps
module empc_top import empc_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic mode_strap_low,
	input wire logic mode_strap_high,
	input wire logic reset_pin_n,
	input wire logic core_power_down,
	input wire logic core_wait_req_n,
	input wire logic irq0_assert,
	input wire empc_core_t core,
	input wire logic mem_read_strobe_n,
	input wire logic mem_write_strobe_n,
	input wire logic boot_mem_select_n,
	input wire logic work_mem_select_n,
	input wire logic io_select_n,
	input wire logic sel_mrd_pin,
	input wire logic sel_mwr_pin,
	input wire logic sel_io_select_n_pin,
	input wire logic sel_addr18_pin,
	input wire logic timer_out,
	input wire logic serial_div2,
	output empc_pins_t pins,
	output logic mem_strobe_o_n,
	output logic mem_strobe_oe,
	output logic mem_wstrobe_o_n,
	output logic mem_wstrobe_oe,
	output logic boot_mem_select_o_n,
	output logic work_mem_select_o_n,
	output logic io_select_o_n,
	output logic io_select_oe,
	output logic outputs_enable,
	output logic osc_enable,
	output logic core_drives_bus,
	output logic host_if_enable,
	output logic serial_clk_div2,
	output logic int_reset_n,
	output empc_mode_t mode
);
	logic [1:0] strap_s1_q, strap_s2_q;
	logic rst_s1_q, rst_s2_q;
	logic mode_valid_q;
	empc_mode_t mode_d, mode_q;
	logic [RST_CNT_W-1:0] cnt_d, cnt_q;
	logic irst_d, irst_q;
	empc_pins_t pins_d, pins_q;
	logic mrd_d, mrd_oe_d, mwr_d, mwr_oe_d, boot_d, work_d, io_select_n_d, io_select_n_oe_d;
	logic mrd_q, mrd_oe_q, mwr_q, mwr_oe_q, boot_q, work_q, io_select_n_q, io_select_n_oe_q;
	logic oen_d, osc_d, core_d, host_d, div_d;
	logic oen_q, osc_q, core_q, host_q, div_q;
	logic norm, adap, probe;

	// strap sync keeps sampling through nrst: a reset value here would hide the
	// real strap from the one-shot mode latch at release
	always_ff @(posedge clk) begin
		strap_s1_q <= {mode_strap_high, mode_strap_low};
		strap_s2_q <= strap_s1_q;
	end

	// reset pin sync; held low through nrst so internal reset starts asserted
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= reset_pin_n;
			rst_s2_q <= rst_s1_q;
		end
	end

	// mode latched once after release, then fixed
	always_comb begin
		mode_d = mode_q;
		if (!mode_valid_q) begin
			unique case (strap_s2_q)
				STRAP_NORMAL: mode_d = EMPC_NORMAL;
				STRAP_ADAPTER: mode_d = EMPC_ADAPTER;
				STRAP_PROBE: mode_d = EMPC_PROBE;
				STRAP_TEST: mode_d = EMPC_TEST;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= EMPC_NORMAL;
			mode_valid_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			// valid rises on the first edge after release and stays until nrst
			mode_valid_q <= 1'b1;
		end
	end

	assign norm = (mode_q == EMPC_NORMAL) && mode_valid_q;
	assign adap = (mode_q == EMPC_ADAPTER) && mode_valid_q;
	// test strap is handled as probe; nothing drives before the mode is latched
	assign probe = (mode_q == EMPC_PROBE) || (mode_q == EMPC_TEST) || !mode_valid_q;

	// internal reset: stretched in normal mode, direct in adapter mode
	// before the mode is latched the stretch path runs, so every boot starts in reset
	always_comb begin
		cnt_d = cnt_q;
		irst_d = irst_q;
		if (adap) begin
			cnt_d = RST_CNT_ZERO;
			irst_d = rst_s2_q;
		end else if (!rst_s2_q) begin
			cnt_d = RST_CNT_LOAD;
			irst_d = 1'b0;
		end else if (cnt_q != RST_CNT_ZERO) begin
			cnt_d = cnt_q - RST_CNT_ONE;
			irst_d = 1'b0;
		end else begin
			irst_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= RST_CNT_LOAD;
			irst_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			irst_q <= irst_d;
		end
	end

	// pin drive and enables
	always_comb begin
		pins_d = '0;
		pins_d.addr_o = core.addr;
		pins_d.data_o = core.data;
		pins_d.ctl_o[C_CLK] = core.core_clock_out;
		pins_d.ctl_o[C_FETCH] = core.opcode_fetch_n;
		pins_d.ctl_o[C_MEM_REQUEST_N] = core.mem_request_n;
		pins_d.ctl_o[C_IO_REQUEST_N] = core.io_request_n;
		pins_d.ctl_o[C_RD] = core.rd_n;
		pins_d.ctl_o[C_WR] = core.wr_n;
		pins_d.ctl_o[C_REFRESH_CYCLE_N] = core.refresh_cycle_n;
		pins_d.ctl_o[C_HALT] = core.halt_n;
		pins_d.ctl_o[C_STAT] = core.cycle_status_out;
		pins_d.ctl_o[C_BACK] = core.bus_grant_ack_n;
		pins_d.ctl_o[C_ECLK] = core.periph_enable_clk;
		pins_d.ctl_o[C_TX0] = core.async_ch0_tx;
		pins_d.ctl_o[C_TX1] = core.async_ch1_tx;
		pins_d.ctl_o[C_ASYNC_CH0_SEND_REQUEST_N] = core.async_ch0_send_request_n;
		pins_d.ctl_o[C_WAIT] = core_wait_req_n;
		// interrupt-0 is open drain: level fixed low, only the enable moves
		pins_d.ctl_o[C_IRQ0] = 1'b0;
		// address 18 carries the timer when the pin-mux does not route the address bit
		if (!sel_addr18_pin) begin
			pins_d.addr_o[ADDR18_BIT] = timer_out;
		end
		if (norm) begin
			pins_d.addr_oe = '1;
			pins_d.data_oe = core.data_oe;
			pins_d.ctl_oe = '1;
			pins_d.ctl_oe[C_WAIT] = 1'b0;
			pins_d.ctl_oe[C_IRQ0] = 1'b0;
			if (core_power_down) begin
				pins_d.addr_oe = '0;
				pins_d.data_oe = 1'b0;
				pins_d.ctl_oe[C_RD] = 1'b0;
				pins_d.ctl_oe[C_WR] = 1'b0;
				// timer output keeps driving; only a routed address bit floats
				if (!sel_addr18_pin) begin
					pins_d.addr_oe[ADDR18_BIT] = 1'b1;
				end
			end
		end else if (adap) begin
			// core pins become inputs; only wait, interrupt-0 and data drive
			pins_d.data_oe = core.data_oe;
			pins_d.ctl_oe[C_WAIT] = 1'b1;
			pins_d.ctl_oe[C_IRQ0] = irq0_assert;
			if (core_power_down) begin
				pins_d.data_oe = 1'b0;
			end
		end
		// other enables stay low in adapter and probe modes
	end

	// strobes and selects, power-down states
	always_comb begin
		mrd_d = mem_read_strobe_n;
		mwr_d = mem_write_strobe_n;
		boot_d = boot_mem_select_n;
		work_d = work_mem_select_n;
		io_select_n_d = io_select_n;
		mrd_oe_d = sel_mrd_pin && norm;
		mwr_oe_d = sel_mwr_pin && norm;
		io_select_n_oe_d = sel_io_select_n_pin && !probe;
		if (core_power_down) begin
			mrd_d = 1'b1;
			mwr_d = 1'b1;
			boot_d = 1'b1;
			work_d = 1'b1;
			io_select_n_oe_d = 1'b0;
		end
		// the shared pin carries memory request when it is not routed as a read strobe
		if (!sel_mrd_pin) begin
			mrd_d = core.mem_request_n;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mrd_q <= 1'b1;
			mwr_q <= 1'b1;
			boot_q <= 1'b1;
			work_q <= 1'b1;
			io_select_n_q <= 1'b1;
			mrd_oe_q <= 1'b0;
			mwr_oe_q <= 1'b0;
			io_select_n_oe_q <= 1'b0;
		end else begin
			mrd_q <= mrd_d;
			mwr_q <= mwr_d;
			boot_q <= boot_d;
			work_q <= work_d;
			io_select_n_q <= io_select_n_d;
			mrd_oe_q <= mrd_oe_d;
			mwr_oe_q <= mwr_oe_d;
			io_select_n_oe_q <= io_select_n_oe_d;
		end
	end

	// global enables, oscillator, host interface and serial clock divider
	always_comb begin
		oen_d = !probe;
		osc_d = norm;
		core_d = norm;
		host_d = !probe && !core_power_down;
		// divide-by-two held off while internal reset is asserted
		div_d = serial_div2 && irst_q;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			oen_q <= 1'b0;
			osc_q <= 1'b0;
			core_q <= 1'b0;
			host_q <= 1'b0;
			div_q <= 1'b0;
		end else begin
			oen_q <= oen_d;
			osc_q <= osc_d;
			core_q <= core_d;
			host_q <= host_d;
			div_q <= div_d;
		end
	end

	// pin drive register: every pin level and enable leaves from a flop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pins_q <= '0;
		end else begin
			pins_q <= pins_d;
		end
	end

	assign pins = pins_q;
	assign mem_strobe_o_n = mrd_q;
	assign mem_strobe_oe = mrd_oe_q;
	assign mem_wstrobe_o_n = mwr_q;
	assign mem_wstrobe_oe = mwr_oe_q;
	assign boot_mem_select_o_n = boot_q;
	assign work_mem_select_o_n = work_q;
	assign io_select_o_n = io_select_n_q;
	assign io_select_oe = io_select_n_oe_q;
	assign outputs_enable = oen_q;
	assign osc_enable = osc_q;
	assign core_drives_bus = core_q;
	assign host_if_enable = host_q;
	assign serial_clk_div2 = div_q;
	assign int_reset_n = irst_q;
	assign mode = mode_q;
endmodule // empc_top

// *** hw/empc_pkg.sv ***
// Purpose: shared constants and types for the emulation mode pin control block
// Assumes: straps are static while running
// Notes: all pin groups are active low where named _n
package empc_pkg;
	localparam int ADDR_W = 20;
	localparam int ADDR18_BIT = 18;
	localparam int DATA_W = 8;
	localparam int RST_STRETCH = 16;
	localparam int RST_CNT_W = 5;
	localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = 5'h00;
	localparam logic [RST_CNT_W-1:0] RST_CNT_ONE = 5'h01;
	localparam logic [RST_CNT_W-1:0] RST_CNT_LOAD = 5'h10;
	localparam logic [1:0] STRAP_NORMAL = 2'h0;
	localparam logic [1:0] STRAP_ADAPTER = 2'h1;
	localparam logic [1:0] STRAP_PROBE = 2'h2;
	localparam logic [1:0] STRAP_TEST = 2'h3;

	typedef enum logic [3:0] {
		EMPC_NORMAL = 4'h1,
		EMPC_ADAPTER = 4'h2,
		EMPC_PROBE = 4'h4,
		EMPC_TEST = 4'h8
	} empc_mode_t;

	// core-side bus values produced by the on-chip processor
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic data_oe;
		logic core_clock_out;
		logic opcode_fetch_n;
		logic mem_request_n;
		logic io_request_n;
		logic rd_n;
		logic wr_n;
		logic refresh_cycle_n;
		logic halt_n;
		logic cycle_status_out;
		logic bus_grant_ack_n;
		logic periph_enable_clk;
		logic async_ch0_tx;
		logic async_ch1_tx;
		logic async_ch0_send_request_n;
	} empc_core_t;

	// pin drive values and enables (enable high = device drives)
	typedef struct packed {
		logic [ADDR_W-1:0] addr_o;
		logic [ADDR_W-1:0] addr_oe;
		logic [DATA_W-1:0] data_o;
		logic data_oe;
		logic [15:0] ctl_o;
		logic [15:0] ctl_oe;
	} empc_pins_t;

	// positions inside ctl_o / ctl_oe
	localparam int C_CLK = 0;
	localparam int C_FETCH = 1;
	localparam int C_MEM_REQUEST_N = 2;
	localparam int C_IO_REQUEST_N = 3;
	localparam int C_RD = 4;
	localparam int C_WR = 5;
	localparam int C_REFRESH_CYCLE_N = 6;
	localparam int C_HALT = 7;
	localparam int C_STAT = 8;
	localparam int C_BACK = 9;
	localparam int C_ECLK = 10;
	localparam int C_TX0 = 11;
	localparam int C_TX1 = 12;
	localparam int C_ASYNC_CH0_SEND_REQUEST_N = 13;
	localparam int C_WAIT = 14;
	localparam int C_IRQ0 = 15;
endpackage

// *** verif/empc_core_model.sv ***
// Purpose: stand-in for the core and emulator bus values
// Assumes: clk is the block clock
// Notes: every field follows a free-running count so stale values show
`timescale 1ns/100ps
module empc_core_model import empc_pkg::*; (
	input wire logic clk,
	output empc_core_t core
);
	logic [7:0] n_q = 8'h00;
	always @(posedge clk) n_q <= #1 n_q + 8'h01;
	// request strobes carry live bus traffic, never a read strobe; the core struct has no
	// interrupt fields, so no interrupt is modelled here
	assign core = {n_q, ~n_q, n_q[3:0], n_q, n_q, n_q[6:0]};
endmodule // empc_core_model

// *** verif/empc_properties.sv ***
// Purpose: port checks for empc_top
// Assumes: straps move only while nrst is low
// Notes: mode checks start 7 edges after release
`timescale 1ns/100ps
module empc_props import empc_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic reset_pin_n,
	input wire logic core_power_down,
	input wire logic core_wait_req_n,
	input wire logic irq0_assert,
	input wire logic sel_mrd_pin,
	input wire logic sel_addr18_pin,
	input wire logic timer_out,
	input wire empc_core_t core,
	input wire logic mem_strobe_o_n,
	input wire empc_pins_t pins,
	input wire logic boot_mem_select_o_n,
	input wire logic work_mem_select_o_n,
	input wire logic osc_enable,
	input wire logic core_drives_bus,
	input wire logic host_if_enable,
	input wire logic int_reset_n,
	input wire empc_mode_t mode
);
	logic [2:0] up_q;
	logic ok;
	logic ad;
	logic pd;
	assign ok = up_q == 3'h7;
	assign ad = ok && mode == EMPC_ADAPTER;
	assign pd = ok && mode == EMPC_NORMAL && core_power_down;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			up_q <= 3'h0;
		end else begin
			up_q <= up_q + {2'h0, !ok};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_osc_emul: assert property (ok && mode != EMPC_NORMAL |-> !osc_enable)
		else $error("osc on");
	a_probe_float: assert property (ok && mode == EMPC_PROBE |-> pins.ctl_oe == '0
		&& pins.addr_oe == '0 && !pins.data_oe) else $error("probe drives");
	a_adapt_float: assert property (ad |-> pins.addr_oe == '0
		&& pins.ctl_oe[C_ASYNC_CH0_SEND_REQUEST_N:C_CLK] == '0 && !core_drives_bus) else $error("adapter drives");
	a_adapt_wait: assert property (ad |=> pins.ctl_oe[C_WAIT]
		&& pins.ctl_o[C_WAIT] == $past(core_wait_req_n)) else $error("wait pin");
	a_irq0_drain: assert property (ad |=> !pins.ctl_o[C_IRQ0]
		&& pins.ctl_oe[C_IRQ0] == $past(irq0_assert)) else $error("irq0 pin");
	a_reset_pass: assert property (ad |-> int_reset_n == $past(reset_pin_n, 3))
		else $error("reset pass");
	a_pd_selects: assert property (pd |=> boot_mem_select_o_n && work_mem_select_o_n)
		else $error("selects low");
	a_pd_float: assert property (pd |=> !pins.data_oe
		&& !host_if_enable && pins.addr_oe[17:0] == '0 && pins.ctl_oe[C_WR:C_RD] == '0)
		else $error("pd drives");
	a_mode_fixed: assert property (ok |-> $stable(mode))
		else $error("mode moved");
	a_core_pass: assert property (ok && mode == EMPC_NORMAL |=> pins.data_o == $past(core.data)
		&& pins.addr_o[17:0] == $past(core.addr[17:0])
		&& pins.ctl_o[C_MEM_REQUEST_N] == $past(core.mem_request_n)) else $error("core pass");
	a_timer_mux: assert property (ok && !sel_addr18_pin |=>
		pins.addr_o[ADDR18_BIT] == $past(timer_out)) else $error("timer mux");
	a_mem_request_n_mux: assert property (ok && !sel_mrd_pin |=>
		mem_strobe_o_n == $past(core.mem_request_n)) else $error("mem_request_n mux");
	c_pd: cover property (pd);
	c_ad_rst: cover property (ad && !reset_pin_n);
	c_probe: cover property (ok && mode == EMPC_PROBE);
	c_mux: cover property (ok && !sel_addr18_pin && !sel_mrd_pin);
endmodule // empc_props

bind empc_top empc_props u_props (.*);

// *** verif/emulation_mode_pin_control_tb.sv ***
// Purpose: directed tests of strap modes, power-down pins and reset paths
// Assumes: straps change while nrst is low, except one move while running
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/100ps
module emulation_mode_pin_control_tb import empc_pkg::*;;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic mode_strap_low, mode_strap_high, reset_pin_n, core_power_down, core_wait_req_n;
	logic irq0_assert, mem_read_strobe_n, mem_write_strobe_n, boot_mem_select_n;
	logic work_mem_select_n, io_select_n, sel_mrd_pin, sel_mwr_pin, sel_io_select_n_pin;
	logic sel_addr18_pin, timer_out, serial_div2, mem_strobe_o_n, mem_strobe_oe;
	logic mem_wstrobe_o_n, mem_wstrobe_oe, boot_mem_select_o_n, work_mem_select_o_n;
	logic io_select_o_n, io_select_oe, outputs_enable, osc_enable, core_drives_bus;
	logic host_if_enable, serial_clk_div2, int_reset_n;
	empc_core_t core;
	empc_pins_t pins;
	empc_mode_t mode;
	int bad_count = 0;
	int num_checks = 0;
	always #4 clk = ~clk;
	empc_core_model u_core (.*);
	empc_top dut (.*);
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s exp %0h got %0h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic boot(input logic [1:0] s);
		nrst = 1'h0;
		{mode_strap_high, mode_strap_low} = s;
		tick(6);
		nrst = 1'h1;
		tick(8);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		int n;
		{reset_pin_n, core_wait_req_n, mem_read_strobe_n, mem_write_strobe_n, boot_mem_select_n,
			work_mem_select_n, io_select_n, sel_mrd_pin, sel_mwr_pin, sel_io_select_n_pin} = 10'h3FF;
		{core_power_down, irq0_assert, sel_addr18_pin, timer_out, serial_div2} = 5'h04;
		for (int m = 0; m < 4; m++) begin
			boot(2'(m));
			chk("mode", {mode, osc_enable, outputs_enable, core_drives_bus, serial_clk_div2},
				{4'h1 << m, m == 0, m < 2, m == 0, 1'h0});
			chk("addr_oe", pins.addr_oe, m == 0 ? 20'hFFFFF : 20'h0);
		end
		boot(2'h0);
		serial_div2 = 1'h1;
		reset_pin_n = 1'h0;
		tick(5);
		chk("irst", {int_reset_n, serial_clk_div2}, 2'h0);
		reset_pin_n = 1'h1;
		n = 0;
		while (int_reset_n !== 1'h1 && n < 40) begin
			tick(1);
			n++;
		end
		chk("stretch", n, RST_STRETCH + 3);
		tick(2);
		chk("div2", serial_clk_div2, 1'h1);
		// strap moved while running must be ignored
		mode_strap_high = 1'h1;
		core_power_down = 1'h1;
		{mem_read_strobe_n, mem_write_strobe_n, boot_mem_select_n, work_mem_select_n, io_select_n} = 5'h0;
		tick(2);
		chk("fixed", mode, EMPC_NORMAL);
		chk("high", {boot_mem_select_o_n, work_mem_select_o_n, mem_strobe_o_n, mem_strobe_oe,
			mem_wstrobe_o_n, mem_wstrobe_oe}, 6'h3F);
		chk("float", {pins.data_oe, pins.ctl_oe[C_WR:C_RD], io_select_oe, pins.addr_oe[17:0],
			host_if_enable}, 32'h0);
		core_power_down = 1'h0;
		tick(2);
		chk("awake", {host_if_enable, boot_mem_select_o_n, io_select_o_n}, 3'h4);
		{sel_mrd_pin, sel_io_select_n_pin, sel_addr18_pin, timer_out} = 4'h1;
		tick(2);
		chk("mux", {mem_strobe_oe, io_select_oe, pins.addr_o[ADDR18_BIT], pins.addr_oe[ADDR18_BIT]},
			4'h3);
		core_power_down = 1'h1;
		tick(2);
		chk("pd_a18", {pins.addr_oe[ADDR18_BIT], pins.addr_oe[17:0] != 18'h0}, 2'h2);
		{core_power_down, timer_out} = 2'h0;
		tick(2);
		chk("timer", pins.addr_o[ADDR18_BIT], 1'h0);
		{sel_mrd_pin, sel_io_select_n_pin, sel_addr18_pin} = 3'h7;
		boot(2'h1);
		{core_wait_req_n, irq0_assert, reset_pin_n} = 3'h2;
		tick(3);
		chk("pass", int_reset_n, 1'h0);
		chk("pins", {pins.ctl_oe[C_WAIT], pins.ctl_o[C_WAIT], pins.ctl_oe[C_IRQ0],
			pins.ctl_o[C_IRQ0], pins.ctl_oe[C_ASYNC_CH0_SEND_REQUEST_N:C_ECLK]}, 8'hA0);
		reset_pin_n = 1'h1;
		tick(3);
		chk("bypass", int_reset_n, 1'h1);
		tick(2);
		chk("keep", {host_if_enable, boot_mem_select_o_n, io_select_oe, io_select_o_n}, 4'hA);
		end_sim;
	end
	initial begin
		#20000;
		bad_count++;
		end_sim;
	end
endmodule // emulation_mode_pin_control_tb
